// ### pkg/vdc_pkg.sv
// shared constants and types for the video digitizer control block
package vdc_pkg;
	// register addresses on the serial port
	localparam logic [7:0] VDC_ADDR_PUMP  = 8'h0c;
	localparam logic [7:0] VDC_ADDR_CFG2  = 8'h0d;
	localparam logic [7:0] VDC_ADDR_TEST  = 8'h0f;
	// reset values
	localparam logic [7:0] VDC_RST_PUMP   = 8'h24;
	localparam logic [7:0] VDC_RST_CFG2   = 8'h00;
	localparam logic [7:0] VDC_RST_TEST   = 8'h00;
	localparam logic [7:0] VDC_RST_DLY    = 8'h80;
	localparam logic [7:0] VDC_RST_WID    = 8'h80;
	// field positions
	localparam int VDC_PUMP_LO  = 2;
	localparam int VDC_OSC_LO   = 5;
	localparam int VDC_VER_LO   = 1;
	localparam int VDC_STEER_B  = 4;
	// arbitrary die version value
	localparam logic [2:0] VDC_SILICON_VERSION = 3'h1;
	// latency: five clock periods from sample to output
	localparam int VDC_LATENCY  = 5;
	localparam int VDC_PHASE_STEPS = 32;
	localparam logic [7:0] VDC_OFFSET_ZERO = 8'h1f;

	typedef struct packed {
		logic [7:0] red;
		logic [7:0] green;
		logic [7:0] blue;
	} vdc_pixel_t;

	typedef struct packed {
		logic       write;
		logic       read;
		logic [7:0] addr;
		logic [7:0] wdata;
	} vdc_regreq_t;

	typedef enum logic [1:0] {
		VDC_CLAMP_IDLE  = 2'b00,
		VDC_CLAMP_DELAY = 2'b01,
		VDC_CLAMP_PULSE = 2'b10
	} vdc_clamp_state_t;
endpackage

// ### verilog/vdc_sample_pipe.sv
// fixed-latency sample pipeline with even/odd port steering
`timescale 1ns/1ps
module vdc_sample_pipe (
	// clock and reset
	input  wire logic              ref_clk,
	input  wire logic              reset_n,
	// control
	input  wire logic              lineStart,
	input  wire logic              dualPort,
	input  wire logic              steerSelect,
	// samples
	input  wire logic              sampleValid,
	input  wire vdc_pkg::vdc_pixel_t sampleIn,
	// outputs
	output vdc_pkg::vdc_pixel_t    portA,
	output vdc_pkg::vdc_pixel_t    portB,
	output logic                   outValid
);
	import vdc_pkg::*;

	vdc_pixel_t pipe [VDC_LATENCY];
	logic       pipeValid [VDC_LATENCY];
	logic       pipeOdd [VDC_LATENCY];
	logic       oddSample;
	logic       next_oddSample;
	vdc_pixel_t next_portA;
	vdc_pixel_t next_portB;

	// first sample after line start counts as 1 (odd)
	always_comb begin
		next_oddSample = oddSample;
		// a sample taken on the line start edge is the odd one, so the next is even
		if (lineStart)
			next_oddSample = !sampleValid;
		else if (sampleValid)
			next_oddSample = ~oddSample;
	end

	// a sample lands on the ports five clocks after it was taken
	genvar i;
	generate
		for (i = 0; i < VDC_LATENCY; i++) begin : g_stage
			// first stage split off so no index below zero is ever elaborated
			if (i == 0) begin : g_first
				always_ff @(posedge ref_clk) begin
					if (!reset_n) begin
						pipe[i]      <= '0;
						pipeValid[i] <= 1'b0;
						pipeOdd[i]   <= 1'b0;
					end else begin
						pipe[i]      <= sampleIn;
						pipeValid[i] <= sampleValid;
						pipeOdd[i]   <= lineStart ? 1'b1 : oddSample;
					end
				end
			end else begin : g_next
				always_ff @(posedge ref_clk) begin
					if (!reset_n) begin
						pipe[i]      <= '0;
						pipeValid[i] <= 1'b0;
						pipeOdd[i]   <= 1'b0;
					end else begin
						pipe[i]      <= pipe[i-1];
						pipeValid[i] <= pipeValid[i-1];
						pipeOdd[i]   <= pipeOdd[i-1];
					end
				end
			end
		end
	endgenerate

	logic toPortA;
	always_comb begin
		// steering 0: even to A; 1: odd to A
		toPortA    = !dualPort || (pipeOdd[VDC_LATENCY-1] == steerSelect);
		next_portA = portA;
		next_portB = portB;
		if (pipeValid[VDC_LATENCY-1]) begin
			if (toPortA)
				next_portA = pipe[VDC_LATENCY-1];
			else
				next_portB = pipe[VDC_LATENCY-1];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			oddSample <= 1'b0;
			portA     <= '0;
			portB     <= '0;
			outValid  <= 1'b0;
		end else begin
			oddSample <= next_oddSample;
			portA     <= next_portA;
			portB     <= next_portB;
			outValid  <= pipeValid[VDC_LATENCY-1];
		end
	end
endmodule

// ### verilog/vdc_control.sv
// control logic of the three-channel video digitizer
`timescale 1ns/1ps
// Behaviour
// - pump_current_select bits 4-2 pick charge pump current 50..500 uA.
// - oscillator_range_select bits 6-5 pick oscillator range.
// - second configuration bits 3-1 read die version, writes ignored.
// - port_steering_select routes even/odd samples to ports A and B.
// - access to register 0F never acknowledged.
// - clamp pulse applied per channel, source chosen by ext_clamp_select.
// - internal pulse start from hold_pulse_delay, length from hold_pulse_width.
// - external source with inactive hold input disables the clamp.
// - gain code 0, 66h, FFh give 500, 700, 1000 mV full scale.
// - offset code shifts output by thirty-one minus the code.
// - sample strobe delayed by 0..31 steps of 11.25 degrees.
// - data and output strobes shift together with sampling strobe.
// - sample reaches outputs five clock periods after capture.
// - ext_clamp_select picks internal or external; polarity 0 active low.
// - delay counted from sync trailing edge, width in pixels.
module vdc_control (
	// clock and reset
	input  wire logic                ref_clk,
	input  wire logic                reset_n,
	// serial port register access
	input  vdc_pkg::vdc_regreq_t     regReq,
	output logic [7:0]               regRdata,
	output logic                     regAck,
	// settings held elsewhere in the register map
	input  wire logic                ext_clamp_select,
	input  wire logic                ext_hold_polarity,
	input  wire logic                dualPort,
	input  wire logic [7:0]          hold_pulse_delay,
	input  wire logic [7:0]          hold_pulse_width,
	input  wire logic [4:0]          sample_delay_steps,
	input  wire logic [7:0]          red_gain_code,
	input  wire logic [7:0]          green_gain_code,
	input  wire logic [7:0]          blue_gain_code,
	input  wire logic [5:0]          red_offset_code,
	input  wire logic [5:0]          green_offset_code,
	input  wire logic [5:0]          blue_offset_code,
	// timing inputs
	input  wire logic                lineSync,
	input  wire logic                extHoldIn,
	input  wire logic                sampleValid,
	input  vdc_pkg::vdc_pixel_t      sampleIn,
	// analog control outputs
	output logic [2:0]               pump_current_select,
	output logic [1:0]               oscillator_range_select,
	output logic                     clampActive,
	output logic                     internal_level_hold_pulse,
	output logic [4:0]               strobeDelay,
	output logic [23:0]              gainCodes,
	output logic [23:0]              offsetShift,
	// data outputs
	output vdc_pkg::vdc_pixel_t      portA,
	output vdc_pkg::vdc_pixel_t      portB,
	output logic                     outValid,
	output logic                     output_data_strobe
);
	import vdc_pkg::*;

	logic [7:0] pumpReg, next_pumpReg;
	logic [7:0] cfg2Reg, next_cfg2Reg;
	logic [7:0] testReg, next_testReg;
	logic [7:0] next_regRdata;

	always_comb begin
		next_pumpReg  = pumpReg;
		next_cfg2Reg  = cfg2Reg;
		next_testReg  = testReg;
		next_regRdata = regRdata;
		if (regReq.write) begin
			case (regReq.addr)
				VDC_ADDR_PUMP: next_pumpReg = regReq.wdata;
				VDC_ADDR_CFG2: next_cfg2Reg = regReq.wdata;
				VDC_ADDR_TEST: next_testReg = regReq.wdata;
				default:       next_pumpReg = pumpReg;
			endcase
		end
		if (regReq.read) begin
			case (regReq.addr)
				VDC_ADDR_PUMP: next_regRdata = pumpReg;
				// version field overrides stored bits on read
				VDC_ADDR_CFG2: next_regRdata = {cfg2Reg[7:4], VDC_SILICON_VERSION,
					cfg2Reg[0]};
				VDC_ADDR_TEST: next_regRdata = testReg;
				default:       next_regRdata = 8'h00;
			endcase
		end
	end

	// test register never acknowledges; regAck high means acknowledged
	assign regAck = (regReq.write || regReq.read) && (regReq.addr != VDC_ADDR_TEST);

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			pumpReg  <= VDC_RST_PUMP;
			cfg2Reg  <= VDC_RST_CFG2;
			testReg  <= VDC_RST_TEST;
			regRdata <= 8'h00;
		end else begin
			pumpReg  <= next_pumpReg;
			cfg2Reg  <= next_cfg2Reg;
			testReg  <= next_testReg;
			regRdata <= next_regRdata;
		end
	end

	// 101 and 111 both mean 500 uA in the analog pump; 110 passes as is
	assign pump_current_select     = pumpReg[VDC_PUMP_LO +: 3];
	assign oscillator_range_select = pumpReg[VDC_OSC_LO +: 2];

	// internal clamp pulse from sync trailing edge
	vdc_clamp_state_t state, next_state;
	logic [7:0] pixCount, next_pixCount;
	logic       syncPrev;
	logic       syncTrail;

	assign syncTrail = syncPrev && !lineSync;

	always_comb begin
		next_state    = state;
		next_pixCount = pixCount;
		// every sync trailing edge restarts the count, so a stale line cannot shift it
		if (syncTrail) begin
			next_pixCount = hold_pulse_delay;
			next_state    = VDC_CLAMP_DELAY;
			if (hold_pulse_delay == 8'h00) begin
				next_state    = VDC_CLAMP_PULSE;
				next_pixCount = hold_pulse_width;
			end
		end else begin
			case (state)
				VDC_CLAMP_IDLE: begin
					next_state = VDC_CLAMP_IDLE;
				end
				VDC_CLAMP_DELAY: begin
					if (sampleValid) begin
						if (pixCount == 8'h01) begin
							next_state    = VDC_CLAMP_PULSE;
							next_pixCount = hold_pulse_width;
						end else
							next_pixCount = pixCount - 8'h01;
					end
				end
				VDC_CLAMP_PULSE: begin
					if (pixCount == 8'h00)
						next_state = VDC_CLAMP_IDLE;
					else if (sampleValid) begin
						next_pixCount = pixCount - 8'h01;
						if (pixCount == 8'h01)
							next_state = VDC_CLAMP_IDLE;
					end
				end
				default: begin
					next_state    = VDC_CLAMP_IDLE;
					next_pixCount = 8'h00;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			state    <= VDC_CLAMP_IDLE;
			pixCount <= 8'h00;
			syncPrev <= 1'b0;
		end else begin
			state    <= next_state;
			pixCount <= next_pixCount;
			syncPrev <= lineSync;
		end
	end

	assign internal_level_hold_pulse = (state == VDC_CLAMP_PULSE) && (pixCount != 8'h00);

	// external input active at selected polarity; inactive level disables clamp
	logic extActive;
	assign extActive   = ext_hold_polarity ? extHoldIn : !extHoldIn;
	assign clampActive = ext_clamp_select ? extActive : internal_level_hold_pulse;

	// gain codes pass straight to the reference converters
	assign gainCodes = {red_gain_code, green_gain_code, blue_gain_code};

	// digital shift equals 31 minus code, two's complement
	always_comb begin
		offsetShift[23:16] = VDC_OFFSET_ZERO - {2'b00, red_offset_code};
		offsetShift[15:8]  = VDC_OFFSET_ZERO - {2'b00, green_offset_code};
		offsetShift[7:0]   = VDC_OFFSET_ZERO - {2'b00, blue_offset_code};
	end

	// one delay drives sampling and data strobes so they move together
	assign strobeDelay = sample_delay_steps;

	logic lineStart;
	assign lineStart = lineSync && !syncPrev;

	vdc_sample_pipe u_pipe (
		.ref_clk     (ref_clk),
		.reset_n     (reset_n),
		.lineStart   (lineStart),
		.dualPort    (dualPort),
		.steerSelect (cfg2Reg[VDC_STEER_B]),
		.sampleValid (sampleValid),
		.sampleIn    (sampleIn),
		.portA       (portA),
		.portB       (portB),
		.outValid    (outValid)
	);

	assign output_data_strobe = outValid;
endmodule

// ### tb/vdc_control_properties.sv
// port assertions for the digitizer control block
`timescale 1ns/1ps
module vdc_control_properties (
	// clock and reset
	input wire logic           ref_clk,
	input wire logic           reset_n,
	// register port
	input vdc_pkg::vdc_regreq_t regReq,
	input wire logic [7:0]     regRdata,
	input wire logic           regAck,
	// settings and timing
	input wire logic           ext_clamp_select,
	input wire logic           ext_hold_polarity,
	input wire logic           extHoldIn,
	input wire logic           sampleValid,
	input wire logic [4:0]     sample_delay_steps,
	input wire logic [5:0]     red_offset_code,
	// outputs
	input wire logic [2:0]     pump_current_select,
	input wire logic [1:0]     oscillator_range_select,
	input wire logic           clampActive,
	input wire logic [4:0]     strobeDelay,
	input wire logic [23:0]    offsetShift,
	input wire logic           outValid,
	input wire logic           output_data_strobe
);
	import vdc_pkg::*;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	logic [7:0] lastW;
	wire        wrPump = regReq.write && regReq.addr == VDC_ADDR_PUMP;
	wire        onTest = (regReq.write || regReq.read) && regReq.addr == VDC_ADDR_TEST;
	wire        rdCfg2 = regReq.read && regReq.addr == VDC_ADDR_CFG2;
	wire        holdOff = ext_clamp_select && ext_hold_polarity != extHoldIn;
	wire        holdOn = ext_clamp_select && ext_hold_polarity == extHoldIn;
	always_ff @(posedge ref_clk) lastW <= regReq.wdata;

	chk_pump_code: assert property (wrPump |=> pump_current_select == lastW[4:2])
		else $error("pump field not taken from write");
	chk_osc_range: assert property (wrPump |=> oscillator_range_select == lastW[6:5])
		else $error("oscillator field not taken from write");
	chk_pump_ack: assert property (wrPump |-> regAck)
		else $error("mapped write not acknowledged");
	chk_test_noack: assert property (onTest |-> !regAck)
		else $error("test register acknowledged");
	chk_version_read: assert property (rdCfg2 |=> regRdata[3:1] == VDC_SILICON_VERSION)
		else $error("version field wrong");
	chk_sample_latency: assert property (sampleValid |-> ##6 outValid)
		else $error("sample latency wrong");
	chk_strobe_tie: assert property (output_data_strobe == outValid)
		else $error("data strobe apart from data");
	chk_phase_steps: assert property (strobeDelay == sample_delay_steps)
		else $error("strobe delay not following setting");
	chk_offset_red: assert property (offsetShift[23:16] == 8'h1f - {2'h0, red_offset_code})
		else $error("offset shift wrong");
	chk_clamp_off: assert property (holdOff [*2] |-> !clampActive)
		else $error("clamp not disabled");
	chk_clamp_ext: assert property (holdOn [*2] |-> clampActive)
		else $error("external clamp not applied");
	cover property (wrPump);
	cover property (sampleValid ##6 outValid);
	cover property (clampActive);
endmodule
bind vdc_control vdc_control_properties chk (.ref_clk, .reset_n, .regReq, .regRdata, .regAck,
	.ext_clamp_select, .ext_hold_polarity, .extHoldIn, .sampleValid, .sample_delay_steps,
	.red_offset_code, .pump_current_select, .oscillator_range_select, .clampActive,
	.strobeDelay, .offsetShift, .outValid, .output_data_strobe);

// ### tb/vdc_host_model.sv
// register-programming host on the serial port side
`timescale 1ns/1ps
module vdc_host_model (
	// clock
	input wire logic            ref_clk,
	// register port
	input wire logic [7:0]      regRdata,
	input wire logic            regAck,
	output vdc_pkg::vdc_regreq_t regReq
);
	import vdc_pkg::*;
	logic lastAck;
	initial regReq = '0;
	// missing acknowledge is noted, never waited on
	task automatic access(input logic wr, input logic [7:0] a, d, output logic [7:0] q);
		@(posedge ref_clk);
		regReq <= '{write: wr, read: !wr, addr: a, wdata: d};
		@(posedge ref_clk);
		lastAck = regAck;
		regReq <= '0;
		#1 q = regRdata;
	endtask
	task automatic init(output logic [7:0] q);
		access(1'b1, VDC_ADDR_TEST, 8'h00, q);
	endtask
	task automatic cfg2(input logic [7:0] d, output logic [7:0] q);
		access(1'b1, VDC_ADDR_CFG2, d & 8'h1e, q);
	endtask
endmodule

// ### tb/test_video_digitizer_control.sv
// self-checking bench for the digitizer control block
`timescale 1ns/1ps
module test_video_digitizer_control;
	import vdc_pkg::*;
	logic ref_clk = 0, reset_n = 0, ext_clamp_select = 0, ext_hold_polarity = 0, dualPort = 0;
	logic lineSync = 0, extHoldIn = 0, sampleValid = 0;
	logic [7:0] hold_pulse_delay = 8'h10, hold_pulse_width = 8'h03;
	logic [4:0] sample_delay_steps = 5'h00, strobeDelay;
	logic [7:0] red_gain_code = 0, green_gain_code = 0, blue_gain_code = 0, regRdata, q;
	logic [5:0] red_offset_code = 0, green_offset_code = 0, blue_offset_code = 0;
	vdc_pixel_t sampleIn = '0, portA, portB;
	vdc_regreq_t regReq;
	logic [2:0] pump_current_select;
	logic [1:0] oscillator_range_select;
	logic regAck, clampActive, internal_level_hold_pulse, outValid, output_data_strobe;
	logic [23:0] gainCodes, offsetShift;
	int miscompares = 0, checks = 0;

	vdc_control dut (.ref_clk, .reset_n, .regReq, .regRdata, .regAck, .ext_clamp_select,
		.ext_hold_polarity, .dualPort, .hold_pulse_delay, .hold_pulse_width, .sample_delay_steps,
		.red_gain_code, .green_gain_code, .blue_gain_code, .red_offset_code, .green_offset_code,
		.blue_offset_code, .lineSync, .extHoldIn, .sampleValid, .sampleIn, .pump_current_select,
		.oscillator_range_select, .clampActive, .internal_level_hold_pulse, .strobeDelay,
		.gainCodes, .offsetShift, .portA, .portB, .outValid, .output_data_strobe);
	vdc_host_model host (.ref_clk, .regRdata, .regAck, .regReq);

	always #2.5 ref_clk = ~ref_clk;

	task automatic check(input logic [23:0] seen, exp);
		checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic results();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask

	task automatic regs_test();
		logic [7:0] w;
		host.access(0, VDC_ADDR_PUMP, 0, q); check(q, VDC_RST_PUMP);
		host.access(0, 8'h0e, 0, q); check(q, 0);
		host.cfg2(8'h1e, q);
		host.access(0, VDC_ADDR_CFG2, 0, q); check(q, {4'h1, VDC_SILICON_VERSION, 1'b0});
		host.access(1, VDC_ADDR_TEST, 0, q); check(host.lastAck, 0);
		for (int i = 0; i < 8; i++) begin
			w = {1'b0, i[1:0], i[2:0], 2'b00};
			host.access(1, VDC_ADDR_PUMP, w, q);
			check({oscillator_range_select, pump_current_select, 2'b00}, w);
			host.access(0, VDC_ADDR_PUMP, 0, q); check(q, w);
		end
	endtask

	task automatic codes_test();
		@(posedge ref_clk);
		{red_gain_code, green_gain_code, blue_gain_code} <= 24'h0066ff;
		{red_offset_code, green_offset_code, blue_offset_code} <= {6'h00, 6'h1f, 6'h3f};
		sample_delay_steps <= 5'h1f;
		@(posedge ref_clk);
		#1 check(gainCodes, 24'h0066ff);
		check(offsetShift, 24'h1f00e0);
		check(strobeDelay, 5'h1f);
	endtask

	// odd then even pixel after a line start, each looked for on its port
	task automatic pix(input logic [23:0] v, input logic dual, toB);
		@(posedge ref_clk); dualPort <= dual; lineSync <= 1;
		@(posedge ref_clk); sampleValid <= 1; sampleIn <= v;
		@(posedge ref_clk); sampleIn <= ~v; lineSync <= 0;
		@(posedge ref_clk); sampleValid <= 0;
		repeat (4) @(posedge ref_clk);
		#1 check(toB ? portB : portA, v);
		@(posedge ref_clk);
		#1 check((toB || !dual) ? portA : portB, ~v);
	endtask

	task automatic clamp_test();
		int n = 0, k = 0;
		@(posedge ref_clk); ext_clamp_select <= 0; lineSync <= 1; sampleValid <= 1;
		@(posedge ref_clk); lineSync <= 0;
		while (!internal_level_hold_pulse && k < 64) begin @(posedge ref_clk); #1 k++; end
		check((k >= 15 && k <= 19), 1);
		while (internal_level_hold_pulse && k < 64) begin @(posedge ref_clk); #1 k++; n++; end
		check(24'(n), 24'(hold_pulse_width));
		for (int i = 0; i < 4; i++) begin
			@(posedge ref_clk); ext_clamp_select <= 1;
			{ext_hold_polarity, extHoldIn} <= i[1:0];
			repeat (3) @(posedge ref_clk);
			#1 check(clampActive, i[1] == i[0]);
		end
		@(posedge ref_clk); sampleValid <= 0;
	endtask

	initial begin
		#100000;
		miscompares++;
		results();
	end

	initial begin
		repeat (3) @(posedge ref_clk);
		reset_n <= 1;
		host.init(q);
		regs_test();
		codes_test();
		host.cfg2(8'h00, q);
		pix(24'h123456, 1, 1);
		host.cfg2(8'h10, q);
		pix(24'h654321, 1, 0);
		pix(24'habcdef, 0, 0);
		clamp_test();
		results();
	end
endmodule
